//--- common/iurm_consts.vh
// Constants for the integer unit register model
// Function
// - Sixteen 32-bit general registers
// - Data registers take byte, word, long
// - Address registers take word, long only
// - User mode uses user stack
// - Master bit picks supervisor stack
// - Calls and returns hit active pointer; exception frames hit entry stack
// - Interrupt entry saves, clears master bit
// - Reset gives interrupt mode
// - Master bit changes by listed paths only
// - Privilege follows supervisor bit only
// - Exceptions push counter and status
// - Program counter steps or reloads
// - Five flags in status low byte
// - Status upper byte supervisor only
// - Vector address is base plus displacement
// - Space codes hold three bits
// - Independent cache enables, lines untouched
// - Reset clears cache control
`ifndef IURM_CONSTS_VH
`define IURM_CONSTS_VH
// ----------------------------
// Register byte offsets
// ----------------------------
`define IURM_OFF_DATA0 8'h00
`define IURM_OFF_ADDR0 8'h20
`define IURM_OFF_ADDR7 8'h3C
`define IURM_OFF_PRG 8'h40
`define IURM_OFF_STW 8'h44
`define IURM_OFF_UST 8'h48
`define IURM_OFF_IST 8'h4C
`define IURM_OFF_MST 8'h50
`define IURM_OFF_VTB 8'h54
`define IURM_OFF_SSC 8'h58
`define IURM_OFF_DSC 8'h5C
`define IURM_OFF_CEN 8'h60
`define IURM_OFF_CMD 8'h64
`define IURM_OFF_VECA 8'h68
`define IURM_OFF_FSR 8'h6C
`define IURM_OFF_FPC 8'h70
`define IURM_OFF_RET 8'h74
// ----------------------------
// Status word fields
// ----------------------------
`define IURM_ST_TH 15
`define IURM_ST_TL 14
`define IURM_ST_S 13
`define IURM_ST_M 12
`define IURM_ST_IPM_HI 10
`define IURM_ST_IPM_LO 8
`define IURM_ST_MASK 16'hF71F
`define IURM_ST_RESET 16'h2700
`define IURM_FLG_MASK 8'h1F
// ----------------------------
// Cache control and command fields
// ----------------------------
`define IURM_CEN_DE 31
`define IURM_CEN_IE 15
`define IURM_CEN_MASK 32'h8000_8000
`define IURM_CMD_EXC 0
`define IURM_CMD_INT 1
`define IURM_CMD_CALL 2
`define IURM_CMD_RET 3
`define IURM_CMD_STEP 4
`define IURM_FC_MASK 32'h0000_0007
`define IURM_FRAME_BYTES 32'h0000_0006
`define IURM_CALL_BYTES 32'h0000_0004
`define IURM_PC_STEP 32'h0000_0002
`define IURM_RESP_OKAY 2'b00
`define IURM_RESP_SLVERR 2'b10
`define IURM_RESP_DECERR 2'b11
`endif

//--- dv/iurm_regs_assertions.sv
// Checker for modes, cache enables and write responses of the register set
`timescale 1ns/1ps
`include "iurm_consts.vh"
module iurm_regs_assertions #(
  parameter AW = 8
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Write address and data
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // Write response
  input wire s_axi_bvalid,
  input wire [1:0] s_axi_bresp,
  // Mode and cache outputs
  input wire supervisor_mode,
  input wire master_mode,
  input wire [1:0] trace_mode,
  input wire inst_cache_en,
  input wire data_cache_en
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  reg [AW-1:0] wa_ff; // Address of the last write taken
  reg [31:0] wd_ff; // Data of the last write taken
  reg [3:0] ws_ff; // Strobes of the last write taken
  reg [3:0] wage_ff; // Cycles since the last data take, saturating
  wire ok_w = (s_axi_bresp == `IURM_RESP_OKAY); // Write was accepted
  // Capture each item as it is taken; only one write is ever open
  always @(posedge clk) begin
    if (s_axi_awvalid && s_axi_awready) begin
      wa_ff <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wd_ff <= s_axi_wdata;
      ws_ff <= s_axi_wstrb;
    end
  end
  // Age counter; saturates so it never wraps back into range
  always @(posedge clk) begin
    if (sys_rst) begin
      wage_ff <= 4'hF;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wage_ff <= 4'h0;
    end else if (wage_ff != 4'hF) begin
      wage_ff <= wage_ff + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_rst_mode;
    $fell(sys_rst) |-> ##2 (supervisor_mode && !master_mode);
  endproperty
  a_rst_mode: assert property (p_rst_mode) else $error("mode wrong after reset");
  property p_rst_cache;
    $fell(sys_rst) |-> (!inst_cache_en && !data_cache_en) [*3];
  endproperty
  a_rst_cache: assert property (p_rst_cache) else $error("cache on after reset");
  property p_int_entry;
    $rose(s_axi_bvalid) && ok_w && wa_ff == `IURM_OFF_CMD && wd_ff[1:0] == 2'h3
      |-> ##1 (supervisor_mode && !master_mode && trace_mode == 2'h0);
  endproperty
  a_int_entry: assert property (p_int_entry) else $error("interrupt entry mode");
  property p_cache_wr;
    $rose(s_axi_bvalid) && ok_w && wa_ff == `IURM_OFF_CEN
      |-> ##1 (inst_cache_en == wd_ff[15] && data_cache_en == wd_ff[31]);
  endproperty
  a_cache_wr: assert property (p_cache_wr) else $error("cache enable mismatch");
  property p_sr_wr;
    $rose(s_axi_bvalid) && ok_w && wa_ff == `IURM_OFF_STW && ws_ff == 4'hF
      |-> ##1 ({trace_mode, supervisor_mode, master_mode} == wd_ff[15:12]);
  endproperty
  a_sr_wr: assert property (p_sr_wr) else $error("status mode bits mismatch");
  property p_master_src;
    $changed(master_mode) |-> wage_ff <= 4'h4;
  endproperty
  a_master_src: assert property (p_master_src) else $error("master bit moved alone");
  property p_priv;
    $rose(s_axi_bvalid) && !supervisor_mode && !$past(supervisor_mode)
      && wa_ff >= `IURM_OFF_UST && wa_ff <= `IURM_OFF_CEN |-> s_axi_bresp == `IURM_RESP_SLVERR;
  endproperty
  a_priv: assert property (p_priv) else $error("user write to control accepted");
  property p_sr_user;
    $rose(s_axi_bvalid) && !supervisor_mode && !$past(supervisor_mode)
      && wa_ff == `IURM_OFF_STW && ws_ff[1] |-> s_axi_bresp == `IURM_RESP_SLVERR;
  endproperty
  a_sr_user: assert property (p_sr_user) else $error("user status high write");
  // Main scenarios reached
  c_int: cover property ($rose(s_axi_bvalid) && wa_ff == `IURM_OFF_CMD && wd_ff[1:0] == 2'h3);
  c_cache: cover property ($rose(data_cache_en));
  c_priv: cover property ($rose(s_axi_bvalid) && s_axi_bresp == `IURM_RESP_SLVERR);
endmodule
bind iurm_regs iurm_regs_assertions #(.AW(AW)) u_iurm_regs_assertions (.clk, .sys_rst,
  .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bresp, .supervisor_mode,
  .master_mode, .trace_mode, .inst_cache_en, .data_cache_en);

//--- dv/iurm_regs_tb.sv
// Self-checking bench for the integer unit register set
`timescale 1ns/1ps
module iurm_regs_tb;
  // ----------------------------------------
  // Bus, mode and bookkeeping signals
  // ----------------------------------------
  localparam [1:0] OKAY = 2'h0;
  localparam [1:0] SLVERR = 2'h2;
  localparam [1:0] DECERR = 2'h3;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg s_axi_awvalid = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00;
  reg s_axi_wvalid = 1'b0;
  reg [31:0] s_axi_wdata = 32'h0000_0000;
  reg [3:0] s_axi_wstrb = 4'h0;
  reg s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0;
  reg [7:0] s_axi_araddr = 8'h00;
  reg s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, trace_mode;
  wire [31:0] s_axi_rdata;
  wire supervisor_mode, master_mode, inst_cache_en, data_cache_en;
  integer errors = 0;
  integer samples_checked = 0;
  integer cycles = 0; // Watchdog count
  integer i;
  always #20 clk = ~clk;
  iurm_regs #(.AW(8)) u_iurm_regs (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .supervisor_mode, .master_mode, .trace_mode,
    .inst_cache_en, .data_cache_en);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task end_sim;
    begin
      $display("compares %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task check(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // Packed: trace, S, M, I and D enables
  task ports(input [5:0] e);
    check("modes", {26'h0, trace_mode, supervisor_mode, master_mode, inst_cache_en,
      data_cache_en}, {26'h0, e});
  endtask
  // Both offered at once, each dropped when taken
  task wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] e);
    reg aw_d, w_d, b_d;
    begin
      aw_d = 1'b0;
      w_d = 1'b0;
      b_d = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!b_d) begin
        @(posedge clk);
        if (!aw_d && s_axi_awready) begin
          aw_d = 1'b1;
          s_axi_awvalid <= 1'b0;
        end
        if (!w_d && s_axi_wready) begin
          w_d = 1'b1;
          s_axi_wvalid <= 1'b0;
        end
        if (s_axi_bvalid) begin
          b_d = 1'b1;
          s_axi_bready <= 1'b0;
          check($sformatf("bresp %h", a), {30'h0, s_axi_bresp}, {30'h0, e});
        end
      end
      // Spare edge between transfers
      @(posedge clk);
    end
  endtask
  // Data compared only on expected OKAY
  task rd(input [7:0] a, input [31:0] e, input [1:0] er);
    reg a_d, r_d;
    begin
      a_d = 1'b0;
      r_d = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!r_d) begin
        @(posedge clk);
        if (!a_d && s_axi_arready) begin
          a_d = 1'b1;
          s_axi_arvalid <= 1'b0;
        end
        if (s_axi_rvalid) begin
          r_d = 1'b1;
          s_axi_rready <= 1'b0;
          check($sformatf("rresp %h", a), {30'h0, s_axi_rresp}, {30'h0, er});
          if (er == OKAY) check($sformatf("rdata %h", a), s_axi_rdata, e);
        end
      end
      @(posedge clk);
    end
  endtask
  // Hang guard; the run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
      errors = errors + 1;
      end_sim;
    end
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h44, 32'h0000_2700, OKAY);
    ports(6'h08);
    rd(8'h60, 32'h0000_0000, OKAY);
    for (i = 0; i < 16; i = i + 1) begin
      rd({i[5:0], 2'b00}, 32'h0000_0000, OKAY);
    end
    $display("test reset done");
    for (i = 0; i < 8; i = i + 1) begin
      wr({i[5:0], 2'b00}, {4{i[7:0]}} ^ 32'hA5A5_5A5A, 4'hF, OKAY);
      rd({i[5:0], 2'b00}, {4{i[7:0]}} ^ 32'hA5A5_5A5A, OKAY);
    end
    wr(8'h0C, 32'hFFFF_FFCC, 4'h1, OKAY);
    rd(8'h0C, 32'hA6A6_59CC, OKAY);
    wr(8'h24, 32'h1234_8001, 4'h3, OKAY);
    rd(8'h24, 32'hFFFF_8001, OKAY);
    wr(8'h28, 32'h0000_0077, 4'h1, SLVERR);
    rd(8'h28, 32'h0000_0000, OKAY);
    $display("test general registers done");
    wr(8'h4C, 32'h0000_1000, 4'hF, OKAY);
    wr(8'h50, 32'h0000_2000, 4'hF, OKAY);
    wr(8'h48, 32'h0000_3000, 4'hF, OKAY);
    wr(8'h54, 32'h0001_0000, 4'hF, OKAY);
    wr(8'h40, 32'h0000_0400, 4'hF, OKAY);
    rd(8'h3C, 32'h0000_1000, OKAY);
    wr(8'h44, 32'h0000_F700, 4'hF, OKAY);
    rd(8'h3C, 32'h0000_2000, OKAY);
    ports(6'h3C);
    wr(8'h58, 32'hFFFF_FFFF, 4'hF, OKAY);
    rd(8'h58, 32'h0000_0007, OKAY);
    wr(8'h64, 32'h0000_4003, 4'hF, OKAY);
    rd(8'h44, 32'h0000_2700, OKAY);
    ports(6'h08);
    rd(8'h3C, 32'h0000_0FFA, OKAY);
    rd(8'h6C, 32'h0000_F700, OKAY);
    rd(8'h70, 32'h0000_0400, OKAY);
    rd(8'h68, 32'h0001_0100, OKAY);
    wr(8'h64, 32'h0000_0008, 4'hF, OKAY);
    rd(8'h44, 32'h0000_F700, OKAY);
    rd(8'h3C, 32'h0000_2000, OKAY);
    wr(8'h64, 32'h0000_0201, 4'hF, OKAY);
    rd(8'h44, 32'h0000_3700, OKAY);
    rd(8'h3C, 32'h0000_1FFA, OKAY);
    rd(8'h68, 32'h0001_0008, OKAY);
    $display("test stacks and exceptions done");
    wr(8'h44, 32'h0000_0000, 4'hF, OKAY);
    rd(8'h3C, 32'h0000_3000, OKAY);
    ports(6'h00);
    wr(8'h4C, 32'h0000_0055, 4'hF, SLVERR);
    wr(8'h44, 32'h0000_3700, 4'h2, SLVERR);
    wr(8'h44, 32'h0000_00FF, 4'h1, OKAY);
    rd(8'h44, 32'h0000_001F, OKAY);
    wr(8'h64, 32'h0000_0008, 4'hF, SLVERR);
    wr(8'h64, 32'h0000_0010, 4'hF, OKAY);
    rd(8'h40, 32'h0000_0402, OKAY);
    wr(8'h64, 32'h0000_0004, 4'hF, OKAY);
    rd(8'h3C, 32'h0000_2FFC, OKAY);
    rd(8'h74, 32'h0000_0402, OKAY);
    wr(8'h64, 32'h0000_0301, 4'hF, OKAY);
    rd(8'h44, 32'h0000_201F, OKAY);
    rd(8'h3C, 32'h0000_0FFA, OKAY);
    $display("test user mode done");
    wr(8'h5C, 32'h0000_000D, 4'hF, OKAY);
    rd(8'h5C, 32'h0000_0005, OKAY);
    wr(8'h60, 32'hFFFF_FFFF, 4'hF, OKAY);
    rd(8'h60, 32'h8000_8000, OKAY);
    ports(6'h0B);
    wr(8'h60, 32'h0000_8000, 4'hF, OKAY);
    wr(8'h60, 32'h8000_0000, 4'h3, SLVERR);
    ports(6'h0A);
    wr(8'h78, 32'h0000_0001, 4'hF, DECERR);
    rd(8'h78, 32'h0000_0000, DECERR);
    wr(8'h68, 32'h0000_0000, 4'hF, DECERR);
    rd(8'h68, 32'h0001_000C, OKAY);
    $display("test space codes and cache done");
    sys_rst <= 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h60, 32'h0000_0000, OKAY);
    rd(8'h44, 32'h0000_2700, OKAY);
    ports(6'h08);
    $display("test second reset done");
    end_sim;
  end
endmodule

//--- hw/iurm_regs.v
// Integer unit register set behind an AXI4-Lite slave
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "iurm_consts.vh"
module iurm_regs #(
  parameter AW = 8
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // AXI4-Lite write address
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [AW-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  input wire [AW-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  // Mode and cache enables for the rest of the core
  output reg supervisor_mode,
  output reg master_mode,
  output reg [1:0] trace_mode,
  output reg inst_cache_en,
  output reg data_cache_en
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Byte-lane merge of a write into an old word
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer k;
    begin
      lane_merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          lane_merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  // Stack selector: 0 user, 1 interrupt, 2 master
  function [1:0] sp_sel;
    input s;
    input m;
    begin
      if (!s) begin
        sp_sel = 2'd0;
      end else if (m) begin
        sp_sel = 2'd2;
      end else begin
        sp_sel = 2'd1;
      end
    end
  endfunction

  // ------------------------------------------------------------
  // Architectural state
  // ------------------------------------------------------------
  reg [31:0] data_regs_ff [0:7]; // Data registers
  reg [31:0] addr_regs_ff [0:6]; // Address registers below A7
  reg [31:0] user_stack_ptr_ff; // User stack
  reg [31:0] interrupt_stack_ptr_ff; // Interrupt stack
  reg [31:0] master_stack_ptr_ff; // Master stack
  reg [31:0] program_counter_ff; // Current instruction address
  reg [15:0] processor_status_word_ff; // Status word with flags
  reg [31:0] vector_table_base_ff; // Vector table base
  reg [2:0] source_space_code_ff; // Source space code
  reg [2:0] destination_space_code_ff; // Destination space code
  reg [31:0] cache_enable_control_ff; // Cache enables
  reg [31:0] vec_addr_ff; // Last vector fetch address
  reg [15:0] frame_sr_ff; // Status word pushed on entry
  reg [31:0] frame_pc_ff; // Counter pushed on entry
  reg [31:0] ret_pc_ff; // Counter pushed by a call

  // Bus holding state
  reg aw_got_ff; // Write address held
  reg w_got_ff; // Write data held
  reg [AW-1:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;

  // ------------------------------------------------------------
  // Active stack pointer
  // ------------------------------------------------------------
  // Mux straight off the status bits, so no copy can go stale
  wire cur_s = processor_status_word_ff[`IURM_ST_S];
  wire cur_m = processor_status_word_ff[`IURM_ST_M];
  wire [1:0] act_sel = sp_sel(cur_s, cur_m);
  reg [31:0] act_sp;

  // Active pointer value for A7, calls and returns; exception frames use ent_sp
  always @* begin
    case (act_sel)
      2'd0: act_sp = user_stack_ptr_ff;
      2'd1: act_sp = interrupt_stack_ptr_ff;
      2'd2: act_sp = master_stack_ptr_ff;
      default: act_sp = user_stack_ptr_ff;
    endcase
  end

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  wire wr_fire = aw_got_ff & w_got_ff & ~s_axi_bvalid;
  wire [7:0] woff = {awaddr_ff[7:2], 2'b00};
  wire w_long = (wstrb_ff == 4'b1111);
  wire w_word = (wstrb_ff == 4'b0011);
  wire [31:0] w_sext = {{16{wdata_ff[15]}}, wdata_ff[15:0]};
  // Address registers take words sign-extended or longs only
  wire [31:0] w_addr = w_long ? wdata_ff : w_sext;
  wire w_addr_ok = w_long | w_word;
  wire w_priv = (woff >= `IURM_OFF_UST) && (woff <= `IURM_OFF_CEN);
  reg [1:0] w_resp; // Response for the current write

  // Decide the write response
  always @* begin
    w_resp = `IURM_RESP_OKAY;
    if (woff > `IURM_OFF_CMD) begin
      w_resp = `IURM_RESP_DECERR; // Unmapped or read-only
    end else if (w_priv && !cur_s) begin
      w_resp = `IURM_RESP_SLVERR;
    end else if (woff == `IURM_OFF_STW && wstrb_ff[1] && !cur_s) begin
      w_resp = `IURM_RESP_SLVERR;
    end else if (woff == `IURM_OFF_CMD && wdata_ff[`IURM_CMD_RET] && !cur_s) begin
      w_resp = `IURM_RESP_SLVERR;
    end else if (woff >= `IURM_OFF_ADDR0 && woff <= `IURM_OFF_ADDR7 && !w_addr_ok) begin
      w_resp = `IURM_RESP_SLVERR;
    end else if ((woff == `IURM_OFF_PRG || w_priv) && !w_long && woff != `IURM_OFF_STW) begin
      w_resp = `IURM_RESP_SLVERR; // Control words move as longs
    end
  end

  wire w_do = wr_fire && (w_resp == `IURM_RESP_OKAY);
  // Status lanes merged; only the low half is kept
  wire [31:0] sr_merge = lane_merge({16'h0, processor_status_word_ff}, wdata_ff, wstrb_ff);

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  wire cmd_go = w_do && (woff == `IURM_OFF_CMD);
  wire c_exc = cmd_go & wdata_ff[`IURM_CMD_EXC];
  wire c_int = c_exc & wdata_ff[`IURM_CMD_INT];
  wire c_call = cmd_go & wdata_ff[`IURM_CMD_CALL] & ~c_exc;
  wire c_ret = cmd_go & wdata_ff[`IURM_CMD_RET] & ~c_exc & ~c_call;
  wire c_step = cmd_go & wdata_ff[`IURM_CMD_STEP] & ~c_exc & ~c_ret;
  // Entry status: supervisor, no trace, master cleared for interrupts
  wire ent_m = c_int ? 1'b0 : cur_m;
  wire [1:0] ent_sel = sp_sel(1'b1, ent_m);
  reg [31:0] ent_sp; // Supervisor stack taking the frame

  // Pick the stack the exception frame lands on
  always @* begin
    if (ent_sel == 2'd2) begin
      ent_sp = master_stack_ptr_ff;
    end else begin
      ent_sp = interrupt_stack_ptr_ff;
    end
  end

  // ------------------------------------------------------------
  // Register file update
  // ------------------------------------------------------------
  integer i;
  // Writes, commands and reset
  always @(posedge clk) begin
    if (sys_rst) begin
      for (i = 0; i < 8; i = i + 1) begin
        data_regs_ff[i] <= 32'h0000_0000;
      end
      for (i = 0; i < 7; i = i + 1) begin
        addr_regs_ff[i] <= 32'h0000_0000;
      end
      user_stack_ptr_ff <= 32'h0000_0000;
      interrupt_stack_ptr_ff <= 32'h0000_0000;
      master_stack_ptr_ff <= 32'h0000_0000;
      program_counter_ff <= 32'h0000_0000;
      processor_status_word_ff <= `IURM_ST_RESET;
      vector_table_base_ff <= 32'h0000_0000;
      source_space_code_ff <= 3'h0;
      destination_space_code_ff <= 3'h0;
      cache_enable_control_ff <= 32'h0000_0000;
      vec_addr_ff <= 32'h0000_0000;
      frame_sr_ff <= 16'h0000;
      frame_pc_ff <= 32'h0000_0000;
      ret_pc_ff <= 32'h0000_0000;
    end else if (c_exc) begin
      // Push status and counter, master bit saved in the frame
      frame_sr_ff <= processor_status_word_ff;
      frame_pc_ff <= program_counter_ff;
      processor_status_word_ff[`IURM_ST_TH] <= 1'b0;
      processor_status_word_ff[`IURM_ST_TL] <= 1'b0;
      processor_status_word_ff[`IURM_ST_S] <= 1'b1;
      processor_status_word_ff[`IURM_ST_M] <= ent_m;
      if (ent_sel == 2'd2) begin
        master_stack_ptr_ff <= ent_sp - `IURM_FRAME_BYTES;
      end else begin
        interrupt_stack_ptr_ff <= ent_sp - `IURM_FRAME_BYTES;
      end
      // Vector slot is four bytes per vector number
      vec_addr_ff <= vector_table_base_ff + {22'h0, wdata_ff[15:8], 2'b00};
    end else if (c_call || c_ret) begin
      // Calls push the counter only; return pops the whole frame
      if (c_call) begin
        ret_pc_ff <= program_counter_ff;
      end else begin
        program_counter_ff <= frame_pc_ff;
        processor_status_word_ff <= frame_sr_ff & `IURM_ST_MASK;
      end
      case (act_sel)
        2'd0: user_stack_ptr_ff <= c_call ? act_sp - `IURM_CALL_BYTES :
                                   act_sp + `IURM_FRAME_BYTES;
        2'd1: interrupt_stack_ptr_ff <= c_call ? act_sp - `IURM_CALL_BYTES :
                                        act_sp + `IURM_FRAME_BYTES;
        default: master_stack_ptr_ff <= c_call ? act_sp - `IURM_CALL_BYTES :
                                        act_sp + `IURM_FRAME_BYTES;
      endcase
    end else if (c_step) begin
      program_counter_ff <= program_counter_ff + `IURM_PC_STEP;
    end else if (w_do) begin
      if (woff < `IURM_OFF_ADDR0) begin
        // Data registers: any byte, word or long lane set
        data_regs_ff[woff[4:2]] <= lane_merge(data_regs_ff[woff[4:2]],
                                              wdata_ff, wstrb_ff);
      end else if (woff < `IURM_OFF_ADDR7) begin
        addr_regs_ff[woff[4:2]] <= w_addr;
      end else begin
        case (woff)
          `IURM_OFF_ADDR7: begin
            // A7 writes land on whichever pointer is active
            case (act_sel)
              2'd0: user_stack_ptr_ff <= w_addr;
              2'd1: interrupt_stack_ptr_ff <= w_addr;
              default: master_stack_ptr_ff <= w_addr;
            endcase
          end
          `IURM_OFF_PRG: program_counter_ff <= wdata_ff;
          `IURM_OFF_STW: begin
            // Whole-word load or flag-byte update
            processor_status_word_ff <= sr_merge[15:0] & `IURM_ST_MASK;
          end
          `IURM_OFF_UST: user_stack_ptr_ff <= wdata_ff;
          `IURM_OFF_IST: interrupt_stack_ptr_ff <= wdata_ff;
          `IURM_OFF_MST: master_stack_ptr_ff <= wdata_ff;
          `IURM_OFF_VTB: vector_table_base_ff <= wdata_ff;
          `IURM_OFF_SSC: source_space_code_ff <= wdata_ff[2:0];
          `IURM_OFF_DSC: destination_space_code_ff <= wdata_ff[2:0];
          // Enables only; no line is touched here
          `IURM_OFF_CEN: cache_enable_control_ff <= wdata_ff & `IURM_CEN_MASK;
          default: begin
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Mode outputs
  // ------------------------------------------------------------
  // Registered copies, one cycle behind
  always @(posedge clk) begin
    if (sys_rst) begin
      supervisor_mode <= 1'b0;
      master_mode <= 1'b0;
      trace_mode <= 2'b00;
      inst_cache_en <= 1'b0;
      data_cache_en <= 1'b0;
    end else begin
      supervisor_mode <= cur_s;
      master_mode <= cur_m;
      trace_mode <= processor_status_word_ff[`IURM_ST_TH:`IURM_ST_TL];
      inst_cache_en <= cache_enable_control_ff[`IURM_CEN_IE];
      data_cache_en <= cache_enable_control_ff[`IURM_CEN_DE];
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite write channels
  // ------------------------------------------------------------
  // Address and data are taken in either order, then answered
  always @(posedge clk) begin
    if (sys_rst) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= {AW{1'b0}};
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IURM_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_got_ff & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_got_ff & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        // Response goes out on the same edge as the write acts
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_resp;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read channels
  // ------------------------------------------------------------
  wire [7:0] roff = {s_axi_araddr[7:2], 2'b00};
  wire r_priv = (roff >= `IURM_OFF_UST) && (roff <= `IURM_OFF_CEN);
  reg [31:0] r_val; // Value for the addressed register
  reg [1:0] r_resp; // Response for the addressed register

  // Read mux; reserved bits read as zero
  always @* begin
    r_val = 32'h0000_0000;
    r_resp = `IURM_RESP_OKAY;
    if (roff < `IURM_OFF_ADDR0) begin
      r_val = data_regs_ff[roff[4:2]];
    end else if (roff < `IURM_OFF_ADDR7) begin
      r_val = addr_regs_ff[roff[4:2]];
    end else if (r_priv && !cur_s) begin
      r_resp = `IURM_RESP_SLVERR;
    end else begin
      case (roff)
        `IURM_OFF_ADDR7: r_val = act_sp;
        `IURM_OFF_PRG: r_val = program_counter_ff;
        // User mode sees only the flag byte
        `IURM_OFF_STW: r_val = cur_s ? {16'h0, processor_status_word_ff} :
                               {24'h0, processor_status_word_ff[7:0]};
        `IURM_OFF_UST: r_val = user_stack_ptr_ff;
        `IURM_OFF_IST: r_val = interrupt_stack_ptr_ff;
        `IURM_OFF_MST: r_val = master_stack_ptr_ff;
        `IURM_OFF_VTB: r_val = vector_table_base_ff;
        `IURM_OFF_SSC: r_val = {29'h0, source_space_code_ff};
        `IURM_OFF_DSC: r_val = {29'h0, destination_space_code_ff};
        `IURM_OFF_CEN: r_val = cache_enable_control_ff;
        `IURM_OFF_CMD: r_val = 32'h0000_0000;
        `IURM_OFF_VECA: r_val = vec_addr_ff;
        `IURM_OFF_FSR: r_val = {16'h0, frame_sr_ff};
        `IURM_OFF_FPC: r_val = frame_pc_ff;
        `IURM_OFF_RET: r_val = ret_pc_ff;
        default: r_resp = `IURM_RESP_DECERR;
      endcase
    end
  end

  // One read at a time, answered the cycle after it is taken
  always @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `IURM_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= r_val;
        s_axi_rresp <= r_resp;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
